// *** verilog/pcu_top.sv ***
// Companding unit: linear PCM to and from 8-bit mu-law or A-law code, serial and parallel.
`timescale 1ns/1ns
`include "pcu_params.svh"

// What this block does
// - Offers serial encode, serial decode, parallel encode and parallel decode modes.
// - Linear side is sign-magnitude, or selectably two's-complement where the variant allows.
// - Compressed code is 8 bits covering 14 linear bits for mu-law or 13 for A-law, sign included.
// - Serial encode compresses every outgoing transmit word with the selected law.
// - Serial decode expands every received word to linear form, sign-magnitude or two's-complement as selected.
// - Parallel encode: write linear sample to port 1, read back 8-bit code.
// - Parallel decode: write 8-bit code to port 1, read back linear value.
// - One write then one read per sample; second write pushes first to transmit.
// - Writes to I/O ports 2 to 7 leave serial port and conversion untouched.
// - Sign-magnitude: sign in top bit, 1 negative, bits between sign and magnitude zero.
// - Mu-law linear limits are 1fff positive and 9fff negative.
// - A-law linear limits are 0fff positive and 8fff negative.
module pcu_top #(
	parameter int TWOS_COMP_OK = 1,
	parameter int FIFO_DEPTH   = 8
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output      logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output      logic        S_AXI_WREADY,
	output      logic [1:0]  S_AXI_BRESP,
	output      logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output      logic        S_AXI_ARREADY,
	output      logic [31:0] S_AXI_RDATA,
	output      logic [1:0]  S_AXI_RRESP,
	output      logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output      logic [7:0]  TX_CODE,
	output      logic        TX_VALID,
	input  wire logic        TX_READY,
	input  wire logic [7:0]  RX_CODE,
	input  wire logic        RX_VALID
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	generate
		if (TWOS_COMP_OK < 0 || TWOS_COMP_OK > 1 || LW > 8) begin : g_bad
			$error("pcu_top: TWOS_COMP_OK must be 0 or 1 and FIFO_DEPTH at most 128");
		end
	endgenerate

	// ****************************************************************
	// Conversion functions
	// ****************************************************************
	function automatic logic [7:0] f_encode(input logic [15:0] x, input logic law,
		input logic tc);
		logic [15:0] a;
		logic [15:0] lim;
		logic [12:0] m;
		logic [2:0]  seg;
		logic [3:0]  man;
		a   = (tc && x[15]) ? 16'(-x) : {1'b0, x[14:0]};
		lim = law ? `PCU_A_MAX : `PCU_MU_MAX;
		if (tc && !law) begin
			a = a + `PCU_MU_BIAS;
		end
		if (a > lim) begin
			a = lim;
		end
		m   = a[12:0];
		seg = 3'h0;
		if (!law) begin
			for (int i = 0; i < 8; i++) begin
				if (m[i+5]) begin
					seg = 3'(i);
				end
			end
			man = 4'(m >> ({1'b0, seg} + 4'h1));
			f_encode = ~{x[15], seg, man};
		end else begin
			for (int i = 1; i < 8; i++) begin
				if (m[i+4]) begin
					seg = 3'(i);
				end
			end
			man = (seg == 3'h0) ? m[4:1] : 4'(m >> seg);
			f_encode = {~x[15], seg, man} ^ `PCU_A_TOGGLE;
		end
	endfunction

	function automatic logic [15:0] f_decode(input logic [7:0] c, input logic law,
		input logic tc);
		logic [7:0]  x;
		logic [12:0] t;
		logic [12:0] mag;
		logic        s;
		x   = law ? (c ^ `PCU_A_TOGGLE) : ~c;
		s   = law ? ~x[7] : x[7];
		if (!law) begin
			t   = (13'({x[3:0], 1'b0}) + 13'(`PCU_MU_BIAS)) << x[6:4];
			mag = t - 13'(`PCU_MU_BIAS);
		end else begin
			t   = (x[6:4] == 3'h0) ? 13'({x[3:0], 1'b1})
				: (13'({x[3:0], 1'b0}) + 13'(`PCU_MU_BIAS)) << (x[6:4] - 3'h1);
			mag = t;
		end
		if (tc) begin
			f_decode = s ? 16'(-{3'h0, mag}) : {3'h0, mag};
		end else begin
			f_decode = {s, 2'h0, t};
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	pcu_pkg::pcu_ctrl_type ctrl;
	pcu_pkg::pcu_wreq_type wreq;
	logic                  aw_full;
	logic                  w_full;
	logic [15:0]           held;
	logic                  pending;
	logic [15:0]           rx_word;
	logic                  rx_full;
	logic                  lost;
	logic                  fifo_in_ready;
	logic [LW-1:0]         fifo_level;

	// ****************************************************************
	// Write decode and datapath
	// ****************************************************************
	wire tc        = (TWOS_COMP_OK != 0) && ctrl.fmt_tc;
	wire serial    = !ctrl.parallel;
	wire wa_ctrl   = wreq.addr == `PCU_CTRL_ADDR;
	wire wa_stat   = wreq.addr == `PCU_STAT_ADDR;
	wire wa_io     = (wreq.addr[7:5] == `PCU_IO_PAGE) && (wreq.addr[1:0] == 2'h0);
	wire wa_p1     = wa_io && (wreq.addr[4:2] == `PCU_IO_PORT1);
	wire wa_ok     = wa_ctrl || wa_stat || wa_io;
	wire p1_req    = aw_full && w_full && wa_p1 && wreq.strb[0];
	wire wr_push   = p1_req && (serial || pending);
	wire wr_go     = aw_full && w_full && !S_AXI_BVALID && !(wr_push && !fifo_in_ready);
	wire p1_wr     = wr_go && p1_req;

	wire [7:0]  enc_code   = f_encode(wreq.data[15:0], ctrl.law, tc);
	wire [15:0] dec_word   = f_decode(wreq.data[7:0], ctrl.law, tc);
	// The encoder wins when software leaves both enabled in parallel mode.
	wire [15:0] par_result = ctrl.enc_en ? {8'h00, enc_code}
		: ctrl.dec_en ? dec_word : wreq.data[15:0];
	wire [7:0]  push_data  = !serial ? held[7:0]
		: ctrl.enc_en ? enc_code : wreq.data[7:0];

	pcu_pkg::pcu_ctrl_type next_ctrl;
	assign next_ctrl = pcu_pkg::pcu_ctrl_type'(wreq.data[4:0]
		& {(TWOS_COMP_OK != 0), 4'hf});

	// ****************************************************************
	// Read decode
	// ****************************************************************
	wire ar_go   = S_AXI_ARVALID && !S_AXI_RVALID;
	wire ra_ctrl = S_AXI_ARADDR == `PCU_CTRL_ADDR;
	wire ra_stat = S_AXI_ARADDR == `PCU_STAT_ADDR;
	wire ra_io   = (S_AXI_ARADDR[7:5] == `PCU_IO_PAGE) && (S_AXI_ARADDR[1:0] == 2'h0);
	wire ra_p1   = ra_io && (S_AXI_ARADDR[4:2] == `PCU_IO_PORT1);
	wire ra_ok   = ra_ctrl || ra_stat || ra_io;
	wire p1_rd   = ar_go && ra_p1;
	wire st_rd   = ar_go && ra_stat;
	wire rx_take = RX_VALID && serial;

	wire [31:0] status = {16'h0000, 8'(fifo_level), 5'h00, lost, rx_full, pending};
	wire [31:0] rd_mux = ra_ctrl ? {27'h0, ctrl}
		: ra_stat ? status
		: ra_p1 ? {16'h0000, serial ? rx_word : held}
		: 32'h0;

	assign S_AXI_AWREADY = !aw_full;
	assign S_AXI_WREADY  = !w_full;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	// ****************************************************************
	// Bus channel registers
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			wreq    <= '0;
		end else begin
			if (S_AXI_AWVALID && !aw_full) begin
				aw_full   <= 1'b1;
				wreq.addr <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end
			if (S_AXI_WVALID && !w_full) begin
				w_full    <= 1'b1;
				wreq.data <= S_AXI_WDATA;
				wreq.strb <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `PCU_RESP_OKAY;
		end else if (wr_go) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= wa_ok ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0;
			S_AXI_RRESP  <= `PCU_RESP_OKAY;
		end else if (ar_go) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_mux;
			S_AXI_RRESP  <= ra_ok ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// ****************************************************************
	// Control and converter state
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ctrl <= pcu_pkg::pcu_ctrl_type'(`PCU_CTRL_RESET);
		end else if (wr_go && wa_ctrl && wreq.strb[0]) begin
			ctrl <= next_ctrl;
		end
	end

	// Parallel results are computed at the write, so the very next read sees them.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			held    <= 16'h0000;
			pending <= 1'b0;
		end else if (p1_wr && !serial) begin
			held    <= par_result;
			pending <= 1'b1;
		end else if (p1_rd && !serial) begin
			pending <= 1'b0;
		end
	end

	// A received word arriving with the read that empties the holder is kept.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			rx_word <= 16'h0000;
			rx_full <= 1'b0;
		end else if (rx_take) begin
			rx_word <= ctrl.dec_en ? f_decode(RX_CODE, ctrl.law, tc) : {8'h00, RX_CODE};
			rx_full <= 1'b1;
		end else if (p1_rd && serial) begin
			rx_full <= 1'b0;
		end
	end

	// Flags a parallel sample overwritten before it was read; a status read clears it.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			lost <= 1'b0;
		end else if (p1_wr && !serial && pending) begin
			lost <= 1'b1;
		end else if (st_rd) begin
			lost <= 1'b0;
		end
	end

	// ****************************************************************
	// Transmit buffer
	// ****************************************************************
	// A full buffer holds back a port-1 write that pushes a code (serial, or parallel with a sample pending), which delays the write response.
	pcu_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.in_valid  (wr_go && wr_push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (TX_CODE),
		.level     (fifo_level)
	);

endmodule

// *** verilog/pcu_params.svh ***
// Register offsets, field positions, reset values and conversion constants of the companding unit.
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define PCU_CTRL_ADDR    8'h00
`define PCU_STAT_ADDR    8'h04
`define PCU_IO_PAGE      3'h1
`define PCU_IO_PORT1     3'h1

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PCU_CTRL_RESET   5'h00
`define PCU_STAT_PEND    0
`define PCU_STAT_RXF     1
`define PCU_STAT_LOST    2
`define PCU_STAT_LVL_LO  8

// ****************************************************************
// Conversion constants
// ****************************************************************
`define PCU_MU_BIAS      16'h0021
`define PCU_MU_MAX       16'h1fff
`define PCU_A_MAX        16'h0fff
`define PCU_A_TOGGLE     8'h55

// ****************************************************************
// Bus responses
// ****************************************************************
`define PCU_RESP_OKAY    2'h0
`define PCU_RESP_SLVERR  2'h2

`endif

// *** verilog/pcu_pkg.sv ***
// Types shared by the companding unit files.
package pcu_pkg;

	typedef enum logic {
		PCU_LAW_MU = 1'b0,
		PCU_LAW_A  = 1'b1
	} pcu_law_type;

	typedef struct packed {
		logic        fmt_tc;
		pcu_law_type law;
		logic        parallel;
		logic        dec_en;
		logic        enc_en;
	} pcu_ctrl_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} pcu_wreq_type;

endpackage

// *** verilog/pcu_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns

module pcu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       in_valid,
	output      logic                       in_ready,
	input  wire logic [WIDTH-1:0]           in_data,
	output      logic                       out_valid,
	input  wire logic                       out_ready,
	output      logic [WIDTH-1:0]           out_data,
	output      logic [$clog2(DEPTH):0]     level
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
			$error("pcu_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign level     = wr_ptr - rd_ptr;
	assign in_ready  = level != (AW+1)'(DEPTH);
	assign out_valid = level != '0;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule

// *** tb/pcu_top_assertions.sv ***
// Concurrent checks on the bus and transmit ports of the companding unit.
`timescale 1ns/1ns
module pcu_chk (
	input wire logic        CORE_CLK,
	input wire logic        RST_N,
	input wire logic [7:0]  S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [7:0]  TX_CODE,
	input wire logic        TX_VALID,
	input wire logic        TX_READY
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;

	property p_rst;
		$rose(RST_N) |-> !TX_VALID && !S_AXI_BVALID && !S_AXI_RVALID;
	endproperty
	property p_tx_hold;
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_CODE);
	endproperty
	// The response rises as the held address is freed, so only the hold after a take is checked.
	property p_b_single;
		aw_hs |=> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	property p_b_time;
		aw_hs |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID;
	endproperty
	property p_unmapped;
		aw_hs && S_AXI_AWADDR >= 8'h40 |-> ##2 S_AXI_BRESP == 2'h2;
	endproperty
	property p_port2;
		aw_hs && S_AXI_AWADDR inside {[8'h28:8'h3c]} |-> ##2 S_AXI_BRESP == 2'h0 && !$rose(TX_VALID);
	endproperty
	property p_rd;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	property p_tx_push;
		$rose(TX_VALID) |-> $rose(S_AXI_BVALID);
	endproperty

	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	a_tx_hold: assert property (p_tx_hold) else $error("code moved while held");
	a_b_single: assert property (p_b_single) else $error("write channels not held");
	a_b_time: assert property (p_b_time) else $error("write answer late");
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	a_port2: assert property (p_port2) else $error("idle port acted");
	a_rd: assert property (p_rd) else $error("read answer late");
	a_tx_push: assert property (p_tx_push) else $error("code without write");
	c_err: cover property (aw_hs ##2 S_AXI_BRESP == 2'h2);
	c_stall: cover property (TX_VALID && !TX_READY);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind pcu_top pcu_chk chk_u (
	.CORE_CLK      (CORE_CLK),
	.RST_N         (RST_N),
	.S_AXI_AWADDR  (S_AXI_AWADDR),
	.S_AXI_AWVALID (S_AXI_AWVALID),
	.S_AXI_AWREADY (S_AXI_AWREADY),
	.S_AXI_WVALID  (S_AXI_WVALID),
	.S_AXI_WREADY  (S_AXI_WREADY),
	.S_AXI_BRESP   (S_AXI_BRESP),
	.S_AXI_BVALID  (S_AXI_BVALID),
	.S_AXI_ARVALID (S_AXI_ARVALID),
	.S_AXI_ARREADY (S_AXI_ARREADY),
	.S_AXI_RVALID  (S_AXI_RVALID),
	.S_AXI_RREADY  (S_AXI_RREADY),
	.TX_CODE       (TX_CODE),
	.TX_VALID      (TX_VALID),
	.TX_READY      (TX_READY)
);

// *** tb/pcu_line.sv ***
// Behavioural model of the serial line partner.
`timescale 1ns/1ns
module pcu_line (
	input  wire logic       clk,
	input  wire logic       stall,
	input  wire logic       send,
	input  wire logic [7:0] code,
	output      logic       ready,
	output      logic [7:0] rx_code,
	output      logic       rx_valid
);
	logic [7:0] last = 8'h00;
	logic       pulse = 1'b0;
	assign ready = !stall;
	assign rx_code = last;
	assign rx_valid = pulse;
	// Between words the code flips, so a stale word is never taken for a fresh one.
	always @(posedge clk) begin
		pulse <= send;
		last <= send ? code : ~last;
	end
endmodule

// *** tb/pcu_top_tb.sv ***
// Self-checking bench for the companding unit.
`timescale 1ns/1ns
module pcu_top_tb;
	logic        CORE_CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic [7:0]  aw = 8'h00;
	logic [7:0]  ar = 8'h00;
	logic [31:0] wd = 32'h00000000;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic        stall = 1'b1;
	logic        send = 1'b0;
	logic [7:0]  sc = 8'h00;
	logic [3:0]  ws = 4'hf;
	wire         awr, wr, bv, arr, rv, txv, txr, rxv;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rd;
	wire  [7:0]  txc, rxc;
	logic [33:0] rq[$];
	logic [7:0]  tq[$];
	int          fails = 0;
	int          checks = 0;
	// Each entry: control byte, linear sample, expected code.
	logic [31:0] tab [6] = '{32'h011fff80, 32'h019fff00, 32'h013fff80,
		32'h090fffaa, 32'h098fff2a, 32'h091fffaa};

	pcu_top dut_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
		.S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.TX_CODE(txc), .TX_VALID(txv), .TX_READY(txr), .RX_CODE(rxc), .RX_VALID(rxv));
	pcu_line line_u (.clk(CORE_CLK), .stall(stall), .send(send), .code(sc),
		.ready(txr), .rx_code(rxc), .rx_valid(rxv));

	initial forever #10 CORE_CLK = ~CORE_CLK;

	// ********************
	// Checking
	// ********************
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang();
		fails++;
		$display("mismatch at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: bus %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: code %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge CORE_CLK) begin
		if (bv && br)
			cmp_bus({bresp, 32'h0}, rq.pop_front());
		if (rv && rr)
			cmp_bus({rresp, rd}, rq.pop_front());
		if (txv && txr)
			cmp_tx(txc, tq.size() > 0 ? tq.pop_front() : ~txc);
	end

	// ********************
	// Bus master
	// ********************
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		rq.push_back({e, 32'h0});
		@(posedge CORE_CLK);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (!bv && n < 60);
		br <= 1'b0;
		if (!bv)
			hang();
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
		int n;
		rq.push_back(e);
		@(posedge CORE_CLK);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
			if (arr)
				arv <= 1'b0;
		end while (!rv && n < 60);
		rr <= 1'b0;
		if (!rv)
			hang();
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (tq.size() > 0 && n < 100) begin
			@(posedge CORE_CLK);
			n++;
		end
		if (tq.size() > 0)
			hang();
	endtask
	task automatic note(input string s);
		$display("test %0s finished", s);
	endtask

	// ********************
	// Scenarios
	// ********************
	initial begin
		int i;
		logic [7:0] b;
		void'($urandom(64));
		repeat (6) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		rd_reg(8'h00, 34'h0);
		rd_reg(8'h04, 34'h0);
		note("reset");
		wr_reg(8'h00, 32'h0, 2'h0);
		for (i = 0; i < 8; i++) begin
			b = 8'($urandom());
			tq.push_back(b);
			wr_reg(8'h24, {24'h0, b}, 2'h0);
		end
		rd_reg(8'h04, 34'h800);
		stall <= 1'b0;
		drain();
		note("buffer");
		for (i = 0; i < 6; i++) begin
			wr_reg(8'h00, {24'h0, tab[i][31:24]}, 2'h0);
			tq.push_back(tab[i][7:0]);
			wr_reg(8'h24, {16'h0, tab[i][23:8]}, 2'h0);
			drain();
			wr_reg(8'h00, {24'h0, tab[i][31:24] | 8'h04}, 2'h0);
			wr_reg(8'h24, {16'h0, tab[i][23:8]}, 2'h0);
			rd_reg(8'h24, {26'h0, tab[i][7:0]});
		end
		note("encode");
		wr_reg(8'h00, 32'h05, 2'h0);
		tq.push_back(8'h80);
		wr_reg(8'h24, 32'h1fff, 2'h0);
		wr_reg(8'h24, 32'h9fff, 2'h0);
		rd_reg(8'h24, 34'h0);
		drain();
		rd_reg(8'h04, 34'h4);
		wr_reg(8'h28, 32'h1fff, 2'h0);
		rd_reg(8'h28, 34'h0);
		rd_reg(8'h04, 34'h0);
		note("overwrite");
		wr_reg(8'h00, 32'h06, 2'h0);
		wr_reg(8'h24, 32'h80, 2'h0);
		rd_reg(8'h24, 34'h1f80);
		wr_reg(8'h24, 32'h00, 2'h0);
		rd_reg(8'h24, 34'h9f80);
		wr_reg(8'h00, 32'h15, 2'h0);
		wr_reg(8'h24, 32'hffff, 2'h0);
		rd_reg(8'h24, 34'h7e);
		wr_reg(8'h00, 32'h16, 2'h0);
		wr_reg(8'h24, 32'h7e, 2'h0);
		rd_reg(8'h24, 34'hfffe);
		wr_reg(8'h00, 32'h0e, 2'h0);
		wr_reg(8'h24, 32'hd5, 2'h0);
		rd_reg(8'h24, 34'h1);
		wr_reg(8'h24, 32'h2a, 2'h0);
		rd_reg(8'h24, 34'h8fc0);
		note("formats");
		wr_reg(8'h00, 32'h02, 2'h0);
		@(posedge CORE_CLK);
		send <= 1'b1;
		@(posedge CORE_CLK);
		send <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		rd_reg(8'h04, 34'h2);
		rd_reg(8'h24, 34'h9f80);
		note("decode");
		ws <= 4'h0;
		wr_reg(8'h00, 32'h1f, 2'h0);
		ws <= 4'hf;
		rd_reg(8'h00, 34'h2);
		note("strobe");
		wr_reg(8'h40, 32'h0, 2'h2);
		rd_reg(8'h40, 34'h200000000);
		note("unmapped");
		report_and_stop();
	end
endmodule
